// ### design/tia_cfg.svh
// Constants of the top-level interrupt aggregator: offsets, bit places, times.
// Assumes a 50 MHz system clock and a 32-bit register bus with byte addresses.
`ifndef TIA_CFG_SVH
`define TIA_CFG_SVH

`define TIA_OFF_STS      8'h00
`define TIA_OFF_EN       8'h04
`define TIA_OFF_CFG      8'h08
`define TIA_OFF_LINE     8'h0c
`define TIA_OFF_PMC      8'h10
`define TIA_OFF_GTC      8'h14
`define TIA_OFF_GTCNT    8'h18

`define TIA_MAC_N        12
`define TIA_GPIO_N       12
`define TIA_B_GPIO       12
`define TIA_B_PME        17
`define TIA_B_GPT        19
`define TIA_B_RDY        30
`define TIA_B_SW         31
`define TIA_B_IRQ_EN     8
`define TIA_B_IRQ_PIN    12
`define TIA_DEAS_LSB     24
`define TIA_DEAS_MSB     31
`define TIA_LINE_EN_LSB  16
`define TIA_LINE_EN_MSB  27
`define TIA_B_PM_E1      14
`define TIA_B_PM_E2      15
`define TIA_B_PM_WOL     9
`define TIA_B_TMR_RUN    29
`define TIA_RLD_MSB      15

`define TIA_CLK_NS       20
`define TIA_DEAS_UNIT_NS 10000
`define TIA_TICK_NS      1000
`define TIA_DEAS_UNIT_CYC ((`TIA_DEAS_UNIT_NS + `TIA_CLK_NS - 1) / `TIA_CLK_NS)
`define TIA_TICK_CYC     ((`TIA_TICK_NS + `TIA_CLK_NS - 1) / `TIA_CLK_NS)
`define TIA_PRE_W        9
`define TIA_TICK_W       6

`endif

// ### design/tia_pkg.sv
// Types of the top-level interrupt aggregator.
// Assumes tia_cfg.svh sits on the include path.
package tia_pkg;
`include "tia_cfg.svh"

	typedef enum logic {TIA_IDLE, TIA_ACK} tia_bus_e;

	typedef struct packed {
		tia_bus_e                st;
		logic                    wait_req;
		logic [31:0]             rdata;
		logic [31:0]             en;
		logic                    oe;
		logic [7:0]              deas;
		logic [`TIA_GPIO_N-1:0]  line_en;
		logic [2:0]              pm_en;
		logic                    run;
		logic [15:0]             reload;
		logic [15:0]             cnt;
		logic [`TIA_TICK_W-1:0]  tick;
		logic                    rdy_done;
		logic                    irq;
		logic [`TIA_PRE_W-1:0]   pre;
		logic [7:0]              dcnt;
	} tia_state_s;

	localparam tia_state_s TIA_STATE_RST = '{st: TIA_IDLE, wait_req: 1'b1, default: '0};
endpackage

// ### design/tia_sync.sv
// Two-flop synchroniser with rising-edge detect for a group of pin inputs.
// Assumes asynchronous pins; o_rise is one cycle per synchronised rise.
`timescale 1ns/1ps
module tia_sync #(
	parameter int N = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst_b,
	input  wire logic         i_ce,
	input  wire logic [N-1:0] i_pin,
	output logic      [N-1:0] o_rise
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
	} tia_sync_s;

	tia_sync_s s_r;
	tia_sync_s s_nxt;

	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = i_pin;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_r <= '0;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_rise = s_r.s2 & ~s_r.s3;
endmodule

// ### design/tia_sticky.sv
// Bank of sticky event flags, cleared by a one-cycle clear strobe per bit.
// Assumes same-clock set and clear; a set in the clear cycle wins.
`timescale 1ns/1ps
module tia_sticky #(
	parameter int N = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst_b,
	input  wire logic         i_ce,
	input  wire logic [N-1:0] i_set,
	input  wire logic [N-1:0] i_clr,
	output logic      [N-1:0] o_flag
);
	typedef struct packed {
		logic [N-1:0] flag;
	} tia_stk_s;

	tia_stk_s s_r;
	tia_stk_s s_nxt;

	always_comb begin
		s_nxt.flag = (s_r.flag & ~i_clr) | i_set;
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_r <= '0;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_flag = s_r.flag;
endmodule

// ### design/tia_top.sv
// Top-level interrupt aggregator with Avalon-MM register slave and IRQ pin.
// Assumes same-clock one-cycle event pulses from MAC and power blocks,
// asynchronous GPIO pins, and an Avalon master that honours waitrequest.
//
// Functional notes
// - Each GPIO line has own flag; top GPIO bit shows any enabled pending line.
// - GPIO reaches pin only with line enable, group enable and output enable.
// - Host MAC event flags and enables live directly in top registers.
// - MAC event drives pin only with its top enable and output enable.
// - Top power-event bit shows an enabled pending power condition.
// - Energy detect per port and wake-on-LAN each have enable and status.
// - Power event reaches pin only with condition, group and output enables.
// - Timer wrapping from zero to all ones sets flag; write one clears.
// - Timer flag drives pin only with run, timer enable and output enable.
// - Setting the soft interrupt enable raises the soft interrupt flag.
// - Ready flag sets once the block is accessible; write one clears.
// - Ready flag drives pin only with its enable and output enable.
// - After any pin deassertion hold it low for the set interval; zero disables.
// - Group top bits clear only when the sub-block flag or its enable is cleared.
`timescale 1ns/1ps
module tia_top
	import tia_pkg::*;
(
	input  wire logic                   i_mclk,
	input  wire logic                   i_rst_b,
	input  wire logic                   i_ce,
	input  wire logic [7:0]             i_avs_address,
	input  wire logic                   i_avs_read,
	input  wire logic                   i_avs_write,
	input  wire logic [31:0]            i_avs_writedata,
	input  wire logic [3:0]             i_avs_byteenable,
	output logic      [31:0]            o_avs_readdata,
	output logic                        o_avs_waitrequest,
	input  wire logic [`TIA_GPIO_N-1:0] i_gpio,
	input  wire logic [`TIA_MAC_N-1:0]  i_mac_evt,
	input  wire logic [1:0]             i_energy_evt,
	input  wire logic                   i_wol_wakeup,
	input  wire logic                   i_wol_magic,
	output logic                        o_irq
);
	tia_state_s s_r;
	tia_state_s s_nxt;

	logic [31:0]             wmask;
	logic [31:0]             wd;
	logic [31:0]             sts_rd;
	logic [31:0]             cfg_rd;
	logic [31:0]             line_rd;
	logic [31:0]             pmc_rd;
	logic [31:0]             gtc_rd;
	logic [31:0]             rd_word;
	logic [31:0]             en_new;
	logic [31:0]             cfg_new;
	logic [31:0]             line_new;
	logic [31:0]             pmc_new;
	logic [31:0]             gtc_new;
	logic                    wr_any;
	logic                    wr_sts;
	logic                    wr_en;
	logic                    wr_cfg;
	logic                    wr_line;
	logic                    wr_pmc;
	logic                    wr_gtc;
	logic [`TIA_GPIO_N-1:0]  gpio_rise;
	logic [`TIA_GPIO_N-1:0]  line_flag;
	logic [`TIA_GPIO_N-1:0]  line_clr;
	logic [`TIA_MAC_N-1:0]   mac_flag;
	logic [`TIA_MAC_N-1:0]   mac_clr;
	logic [2:0]              pm_flag;
	logic [2:0]              pm_set;
	logic [2:0]              pm_clr;
	logic [2:0]              misc_flag;
	logic [2:0]              misc_set;
	logic [2:0]              misc_clr;
	logic                    gpio_any;
	logic                    pme_any;
	logic                    gpt_wrap;
	logic                    sw_set;
	logic                    irq_req;

	// Misc flags: bit 0 timer, bit 1 ready, bit 2 soft
	tia_sync #(.N(`TIA_GPIO_N)) u_gpio_sync (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_pin   (i_gpio),
		.o_rise  (gpio_rise)
	);

	tia_sticky #(.N(`TIA_GPIO_N)) u_line (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_set   (gpio_rise),
		.i_clr   (line_clr),
		.o_flag  (line_flag)
	);

	tia_sticky #(.N(`TIA_MAC_N)) u_mac (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_set   (i_mac_evt),
		.i_clr   (mac_clr),
		.o_flag  (mac_flag)
	);

	tia_sticky #(.N(3)) u_pm (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_set   (pm_set),
		.i_clr   (pm_clr),
		.o_flag  (pm_flag)
	);

	tia_sticky #(.N(3)) u_misc (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_set   (misc_set),
		.i_clr   (misc_clr),
		.o_flag  (misc_flag)
	);

	assign wmask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
	                 {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	assign wd     = i_avs_writedata & wmask;
	assign wr_any = (s_r.st == TIA_ACK) && i_avs_write;

	assign gpio_any = |(line_flag & s_r.line_en);
	assign pme_any  = |(pm_flag & s_r.pm_en);
	assign pm_set   = {i_wol_wakeup | i_wol_magic, i_energy_evt};
	assign gpt_wrap = s_r.run && (s_r.tick == '0) && (s_r.cnt == '0);

	always_comb begin
		sts_rd = '0;
		sts_rd[`TIA_MAC_N-1:0] = mac_flag;
		sts_rd[`TIA_B_GPIO]    = gpio_any;
		sts_rd[`TIA_B_PME]     = pme_any;
		sts_rd[`TIA_B_GPT]     = misc_flag[0];
		sts_rd[`TIA_B_RDY]     = misc_flag[1];
		sts_rd[`TIA_B_SW]      = misc_flag[2];
		cfg_rd = '0;
		cfg_rd[`TIA_DEAS_MSB:`TIA_DEAS_LSB] = s_r.deas;
		cfg_rd[`TIA_B_IRQ_EN]  = s_r.oe;
		cfg_rd[`TIA_B_IRQ_PIN] = s_r.irq;
		line_rd = '0;
		line_rd[`TIA_LINE_EN_MSB:`TIA_LINE_EN_LSB] = s_r.line_en;
		line_rd[`TIA_GPIO_N-1:0] = line_flag;
		pmc_rd = '0;
		pmc_rd[`TIA_B_PM_E1]  = s_r.pm_en[0];
		pmc_rd[`TIA_B_PM_E2]  = s_r.pm_en[1];
		pmc_rd[`TIA_B_PM_WOL] = s_r.pm_en[2];
		pmc_rd[2:0]           = pm_flag;
		gtc_rd = '0;
		gtc_rd[`TIA_B_TMR_RUN]  = s_r.run;
		gtc_rd[`TIA_RLD_MSB:0]  = s_r.reload;
	end

	assign en_new   = (s_r.en & ~wmask) | wd;
	assign cfg_new  = (cfg_rd & ~wmask) | wd;
	assign line_new = (line_rd & ~wmask) | wd;
	assign pmc_new  = (pmc_rd & ~wmask) | wd;
	assign gtc_new  = (gtc_rd & ~wmask) | wd;

	// Address decode for writes and read mux
	always_comb begin
		wr_sts  = 1'b0;
		wr_en   = 1'b0;
		wr_cfg  = 1'b0;
		wr_line = 1'b0;
		wr_pmc  = 1'b0;
		wr_gtc  = 1'b0;
		rd_word = '0;
		if (i_avs_address == `TIA_OFF_STS) begin
			wr_sts  = wr_any;
			rd_word = sts_rd;
		end else if (i_avs_address == `TIA_OFF_EN) begin
			wr_en   = wr_any;
			rd_word = s_r.en;
		end else if (i_avs_address == `TIA_OFF_CFG) begin
			wr_cfg  = wr_any;
			rd_word = cfg_rd;
		end else if (i_avs_address == `TIA_OFF_LINE) begin
			wr_line = wr_any;
			rd_word = line_rd;
		end else if (i_avs_address == `TIA_OFF_PMC) begin
			wr_pmc  = wr_any;
			rd_word = pmc_rd;
		end else if (i_avs_address == `TIA_OFF_GTC) begin
			wr_gtc  = wr_any;
			rd_word = gtc_rd;
		end else if (i_avs_address == `TIA_OFF_GTCNT) begin
			rd_word = {16'h0000, s_r.cnt};
		end
	end

	// Write-one-to-clear strobes; group top bits are not cleared here
	assign mac_clr  = wr_sts ? wd[`TIA_MAC_N-1:0] : '0;
	assign line_clr = wr_line ? wd[`TIA_GPIO_N-1:0] : '0;
	assign pm_clr   = wr_pmc ? wd[2:0] : '0;
	assign misc_clr = wr_sts ? {wd[`TIA_B_SW], wd[`TIA_B_RDY], wd[`TIA_B_GPT]} : 3'h0;
	assign sw_set   = wr_en && en_new[`TIA_B_SW] && !s_r.en[`TIA_B_SW];
	assign misc_set = {sw_set, !s_r.rdy_done, gpt_wrap};

	always_comb begin
		irq_req = 1'b0;
		if (s_r.oe) begin
			irq_req = |(mac_flag & s_r.en[`TIA_MAC_N-1:0])
			        | (gpio_any & s_r.en[`TIA_B_GPIO])
			        | (pme_any & s_r.en[`TIA_B_PME])
			        | (misc_flag[0] & s_r.run & s_r.en[`TIA_B_GPT])
			        | (misc_flag[1] & s_r.en[`TIA_B_RDY])
			        | (misc_flag[2] & s_r.en[`TIA_B_SW]);
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdy_done = 1'b1;
		case (s_r.st)
			TIA_IDLE: begin
				if (i_avs_read || i_avs_write) begin
					s_nxt.st       = TIA_ACK;
					s_nxt.wait_req = 1'b0;
					s_nxt.rdata    = i_avs_read ? rd_word : '0;
				end
			end
			TIA_ACK: begin
				s_nxt.st       = TIA_IDLE;
				s_nxt.wait_req = 1'b1;
			end
		endcase
		// Timer counts down once per tick and wraps through all ones
		if (s_r.run) begin
			if (s_r.tick == '0) begin
				s_nxt.tick = `TIA_TICK_W'(`TIA_TICK_CYC - 1);
				s_nxt.cnt  = s_r.cnt - 16'h0001;
			end else begin
				s_nxt.tick = s_r.tick - `TIA_TICK_W'(1);
			end
		end
		if (wr_en) begin
			s_nxt.en = en_new;
		end
		if (wr_cfg) begin
			s_nxt.deas = cfg_new[`TIA_DEAS_MSB:`TIA_DEAS_LSB];
			s_nxt.oe   = cfg_new[`TIA_B_IRQ_EN];
		end
		if (wr_line) begin
			s_nxt.line_en = line_new[`TIA_LINE_EN_MSB:`TIA_LINE_EN_LSB];
		end
		if (wr_pmc) begin
			s_nxt.pm_en = {pmc_new[`TIA_B_PM_WOL], pmc_new[`TIA_B_PM_E2],
			               pmc_new[`TIA_B_PM_E1]};
		end
		if (wr_gtc) begin
			s_nxt.run    = gtc_new[`TIA_B_TMR_RUN];
			s_nxt.reload = gtc_new[`TIA_RLD_MSB:0];
			if (gtc_new[`TIA_B_TMR_RUN] && !s_r.run) begin
				s_nxt.cnt  = gtc_new[`TIA_RLD_MSB:0];
				s_nxt.tick = `TIA_TICK_W'(`TIA_TICK_CYC - 1);
			end
		end
		// Deassertion hold-off
		if (s_r.dcnt != '0) begin
			if (s_r.pre == '0) begin
				s_nxt.pre  = `TIA_PRE_W'(`TIA_DEAS_UNIT_CYC - 1);
				s_nxt.dcnt = s_r.dcnt - 8'h01;
			end else begin
				s_nxt.pre = s_r.pre - `TIA_PRE_W'(1);
			end
		end
		if (s_r.irq && !irq_req) begin
			s_nxt.irq  = 1'b0;
			s_nxt.dcnt = s_r.deas;
			s_nxt.pre  = `TIA_PRE_W'(`TIA_DEAS_UNIT_CYC - 1);
		end else if (!s_r.irq && irq_req && (s_r.dcnt == '0)) begin
			s_nxt.irq = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_r <= TIA_STATE_RST;
		end else if (i_ce) begin
			s_r <= s_nxt;
		end
	end

	assign o_avs_readdata    = s_r.rdata;
	assign o_avs_waitrequest = s_r.wait_req;
	assign o_irq             = s_r.irq;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);

	property p_gpio_top;
		i_ce && |(gpio_rise & s_r.line_en) && !wr_any |=> gpio_any;
	endproperty
	a_gpio_top: assert property (p_gpio_top) else $error("GPIO top bit not set");

	property p_oe_gate;
		i_ce && !s_r.oe |=> !o_irq;
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("IRQ high without output enable");

	property p_mac_drive;
		i_ce && |(mac_flag & s_r.en[`TIA_MAC_N-1:0]) && s_r.oe && !o_irq
		&& (s_r.dcnt == '0) && !wr_any |=> o_irq;
	endproperty
	a_mac_drive: assert property (p_mac_drive) else $error("MAC event did not raise IRQ");

	property p_energy_flag;
		i_ce && (i_energy_evt != 2'h0) && !wr_any |=> (pm_flag[1:0] != 2'h0);
	endproperty
	a_energy_flag: assert property (p_energy_flag) else $error("Energy flag lost");

	property p_gpt_set;
		i_ce && gpt_wrap |=> misc_flag[0] && (s_r.cnt == 16'hffff);
	endproperty
	a_gpt_set: assert property (p_gpt_set) else $error("Timer wrap flag missing");

	property p_sw_set;
		i_ce && sw_set |=> misc_flag[2] ##1 misc_flag[2] || !i_ce || wr_any;
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("Soft interrupt not raised");

	property p_ready;
		i_ce && !s_r.rdy_done |=> misc_flag[1] && s_r.rdy_done;
	endproperty
	a_ready: assert property (p_ready) else $error("Ready flag not set after reset");

	property p_holdoff;
		$fell(o_irq) && (s_r.deas != 8'h00) |-> !o_irq [*8];
	endproperty
	a_holdoff: assert property (p_holdoff) else $error("IRQ reasserted in hold-off");

	property p_top_sticky;
		i_ce && gpio_any && wr_sts |=> gpio_any;
	endproperty
	a_top_sticky: assert property (p_top_sticky) else $error("GPIO top bit cleared at top");

	property p_irq_hold;
		i_ce && o_irq && irq_req |=> o_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("IRQ dropped while pending");

endmodule

// ### dv/testbench.sv
// Self-checking bench for the top-level interrupt aggregator.
// Assumes tia_pkg, tia_cfg.svh and the design modules are compiled first.
`timescale 1ns/1ps
`include "tia_cfg.svh"
module testbench
	import tia_pkg::*;
;
	typedef struct {
		logic [7:0]  addr;
		logic [31:0] exp;
		logic [31:0] mask;
	} tia_note_s;

	logic        mclk;
	logic        rst_b;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [11:0] gpio;
	logic [11:0] mac_evt;
	logic [1:0]  energy_evt;
	logic        wol_wakeup;
	logic        wol_magic;
	logic        irq;
	logic [11:0] m;
	int          bad_count;
	int          check_count;
	tia_note_s   notes[$];
	tia_note_s   n;

	localparam logic [31:0] IRQ_BIT = 32'h0000_1000;

	tia_top DUT (
		.i_mclk           (mclk),
		.i_rst_b          (rst_b),
		.i_ce             (1'b1),
		.i_avs_address    (address),
		.i_avs_read       (read),
		.i_avs_write      (write),
		.i_avs_writedata  (writedata),
		.i_avs_byteenable (4'hf),
		.o_avs_readdata   (readdata),
		.o_avs_waitrequest(waitrequest),
		.i_gpio           (gpio),
		.i_mac_evt        (mac_evt),
		.i_energy_evt     (energy_evt),
		.i_wol_wakeup     (wol_wakeup),
		.i_wol_magic      (wol_magic),
		.o_irq            (irq)
	);

	initial mclk = 1'b0;
	always #10 mclk = ~mclk;

	task automatic end_of_test();
		if (bad_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		address   <= a;
		writedata <= d;
		write     <= wr;
		read      <= ~wr;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50) begin
			bad_count++;
			end_of_test();
		end
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
		notes.push_back('{addr: a, exp: e, mask: mk});
		bus(1'b0, a, 32'h0);
	endtask

	task automatic irq_is(input logic v);
		rd(`TIA_OFF_CFG, v ? IRQ_BIT : 32'h0, IRQ_BIT);
	endtask

	// Read results compared against the oldest note
	always @(posedge mclk) begin
		if (read === 1'b1 && waitrequest === 1'b0) begin
			n = notes.pop_front();
			check_count++;
			if ((readdata & n.mask) !== (n.exp & n.mask)) begin
				bad_count++;
				$display("wrong value reg %h expected %h seen %h", n.addr, n.exp & n.mask,
					readdata & n.mask);
			end
			// Pin itself must agree with its readback
			if (n.addr == `TIA_OFF_CFG && n.mask == IRQ_BIT) begin
				check_count++;
				if (irq !== n.exp[`TIA_B_IRQ_PIN]) begin
					bad_count++;
					$display("wrong value irq pin expected %b seen %b",
						n.exp[`TIA_B_IRQ_PIN], irq);
				end
			end
		end
	end

	task automatic mac_pulse(input logic [11:0] b);
		@(posedge mclk);
		mac_evt <= b;
		@(posedge mclk);
		mac_evt <= 12'h000;
	endtask

	task automatic pm_pulse(input logic [1:0] e, input logic wk, input logic mg);
		@(posedge mclk);
		energy_evt <= e;
		wol_wakeup <= wk;
		wol_magic  <= mg;
		@(posedge mclk);
		energy_evt <= 2'h0;
		wol_wakeup <= 1'b0;
		wol_magic  <= 1'b0;
	endtask

	task automatic gpio_rise(input int ln);
		@(posedge mclk);
		gpio[ln] <= 1'b1;
		repeat (6) @(posedge mclk);
		gpio[ln] <= 1'b0;
	endtask

	initial begin
		rst_b = 1'b0; address = 8'h00; read = 1'b0; write = 1'b0; writedata = 32'h0;
		gpio = 12'h000; mac_evt = 12'h000; energy_evt = 2'h0;
		wol_wakeup = 1'b0; wol_magic = 1'b0; bad_count = 0; check_count = 0;
		void'($urandom(32'hba18829b));
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		rd(`TIA_OFF_STS, 32'h4000_0000, 32'hffff_ffff);
		rd(`TIA_OFF_EN, 32'h0, 32'hffff_ffff);
		rd(8'h1c, 32'h0, 32'hffff_ffff);
		irq_is(1'b0);
		wr(`TIA_OFF_CFG, 32'h0000_0100);
		wr(`TIA_OFF_EN, 32'h4000_0000);
		irq_is(1'b1);
		wr(`TIA_OFF_STS, 32'h4000_0000);
		rd(`TIA_OFF_STS, 32'h0, 32'hffff_ffff);
		irq_is(1'b0);
		// Host MAC events, random group
		m = 12'($urandom()) | 12'h001;
		mac_pulse(m);
		rd(`TIA_OFF_STS, {20'h0, m}, 32'h0000_0fff);
		irq_is(1'b0);
		wr(`TIA_OFF_EN, {20'h0, m});
		irq_is(1'b1);
		wr(`TIA_OFF_CFG, 32'h0);
		irq_is(1'b0);
		wr(`TIA_OFF_CFG, 32'h0000_0100);
		irq_is(1'b1);
		wr(`TIA_OFF_STS, {20'h0, m});
		rd(`TIA_OFF_STS, 32'h0, 32'h0000_0fff);
		irq_is(1'b0);
		// GPIO lines: only line 3 enabled
		wr(`TIA_OFF_LINE, 32'h0008_0000);
		gpio_rise(5);
		rd(`TIA_OFF_LINE, 32'h0000_0020, 32'h0000_0fff);
		rd(`TIA_OFF_STS, 32'h0, 32'h0000_1000);
		gpio_rise(3);
		rd(`TIA_OFF_STS, 32'h0000_1000, 32'h0000_1000);
		irq_is(1'b0);
		wr(`TIA_OFF_EN, 32'h0000_1000);
		irq_is(1'b1);
		wr(`TIA_OFF_STS, 32'h0000_1000);
		rd(`TIA_OFF_STS, 32'h0000_1000, 32'h0000_1000);
		wr(`TIA_OFF_LINE, 32'h0008_0008);
		rd(`TIA_OFF_STS, 32'h0, 32'h0000_1000);
		irq_is(1'b0);
		wr(`TIA_OFF_LINE, 32'h0008_0020);
		// Power conditions: only port1 energy enabled
		wr(`TIA_OFF_PMC, 32'h0000_4000);
		pm_pulse(2'b10, 1'b0, 1'b0);
		rd(`TIA_OFF_PMC, 32'h2, 32'h7);
		rd(`TIA_OFF_STS, 32'h0, 32'h0002_0000);
		pm_pulse(2'b01, 1'b0, 1'b0);
		rd(`TIA_OFF_STS, 32'h0002_0000, 32'h0002_0000);
		irq_is(1'b0);
		wr(`TIA_OFF_EN, 32'h0002_0000);
		irq_is(1'b1);
		wr(`TIA_OFF_PMC, 32'h0000_4003);
		rd(`TIA_OFF_STS, 32'h0, 32'h0002_0000);
		wr(`TIA_OFF_PMC, 32'h0000_0200);
		pm_pulse(2'b00, 1'b1, 1'b0);
		rd(`TIA_OFF_STS, 32'h0002_0000, 32'h0002_0000);
		wr(`TIA_OFF_PMC, 32'h0000_0204);
		pm_pulse(2'b00, 1'b0, 1'b1);
		rd(`TIA_OFF_PMC, 32'h4, 32'h7);
		wr(`TIA_OFF_PMC, 32'h0000_0004);
		irq_is(1'b0);
		// Timer: reload 2 wraps after three ticks
		wr(`TIA_OFF_GTC, 32'h2000_0002);
		rd(`TIA_OFF_GTCNT, 32'h0000_0002, 32'hffff_ffff);
		rd(`TIA_OFF_STS, 32'h0, 32'h0008_0000);
		repeat (200) @(posedge mclk);
		rd(`TIA_OFF_STS, 32'h0008_0000, 32'h0008_0000);
		wr(`TIA_OFF_EN, 32'h0008_0000);
		irq_is(1'b1);
		wr(`TIA_OFF_GTC, 32'h0000_0002);
		irq_is(1'b0);
		wr(`TIA_OFF_STS, 32'h0008_0000);
		rd(`TIA_OFF_STS, 32'h0, 32'h0008_0000);
		// Soft interrupt on demand
		wr(`TIA_OFF_EN, 32'h8000_0000);
		rd(`TIA_OFF_STS, 32'h8000_0000, 32'h8000_0000);
		irq_is(1'b1);
		wr(`TIA_OFF_STS, 32'h8000_0000);
		irq_is(1'b0);
		// Deassert hold-off of one unit, event right after the fall
		wr(`TIA_OFF_CFG, 32'h0100_0100);
		wr(`TIA_OFF_EN, 32'h0000_0001);
		mac_pulse(12'h001);
		irq_is(1'b1);
		wr(`TIA_OFF_STS, 32'h0000_0001);
		mac_pulse(12'h001);
		repeat (400) @(posedge mclk);
		irq_is(1'b0);
		repeat (150) @(posedge mclk);
		irq_is(1'b1);
		end_of_test();
	end
endmodule
